// File: src/etx_defs.vh
`ifndef ETX_DEFS_VH
`define ETX_DEFS_VH
`define ETX_CLK_HZ      10000000
`define ETX_SEC_MS      1000
`define ETX_FLASH_MS    250
`define ETX_MIN_S       60
`define ETX_A_TEST      8'h00
`define ETX_A_LINE      8'h04
`define ETX_A_CMD       8'h08
`define ETX_A_STAT      8'h0C
`define ETX_A_HIST      8'h10
`define ETX_A_ELAP      8'h14
`define ETX_A_ERRS      8'h18
`define ETX_A_HPTR      8'h1C
`define ETX_A_HREC      8'h20
`define ETX_A_USER0     8'h24
`define ETX_A_USER1     8'h28
`define ETX_A_USER2     8'h2C
`define ETX_F_PAT       4:0
`define ETX_F_DUR       7:5
`define ETX_F_STO       9:8
`define ETX_F_RES       11:10
`define ETX_F_RATE      14:12
`define ETX_F_E1        0
`define ETX_F_FRM       3:1
`define ETX_F_ASEL      5:4
`define ETX_F_AMODE     7:6
`define ETX_C_RESTART   0
`define ETX_C_SINGLE    1
`define ETX_C_LEFT      2
`define ETX_C_RIGHT     3
`define ETX_C_CLEAR     4
`define ETX_C_FREEZE    5
`define ETX_C_SHOW      6
`define ETX_C_RESYNC    7
`define ETX_FR_SF       3'h4
`define ETX_FR_ESF      3'h3
`define ETX_FR_SLC      3'h5
`define ETX_FR_T1DM     3'h6
`define ETX_AS_AIS      2'h0
`define ETX_AS_YEL      2'h1
`define ETX_AS_RAI      2'h1
`define ETX_AS_MRAI     2'h2
`define ETX_AS_LOS      2'h3
`define ETX_AM_OFF      2'h0
`define ETX_AM_ON       2'h1
`define ETX_AM_AUTO     2'h2
`define ETX_T1_B2       3'h1
`define ETX_T1DM_SLOT   5'h17
`define ETX_T1DM_YBIT   3'h5
`define ETX_E1_ABIT     3'h2
`define ETX_E1_YBIT     3'h5
`define ETX_E1_TS16     5'h10
`define ETX_P_LIVE      5'h15
`define ETX_P_3IN24     24'h44_0004
`endif

// File: src/etx_ctrl.v
`timescale 1ns/1ps
`include "etx_defs.vh"
module etx_ctrl #(
  parameter ALARM_W      = 12,
  parameter HIST_AW      = 6,
  parameter SEC_CYCLES   = `ETX_SEC_MS * (`ETX_CLK_HZ / 1000),
  parameter FLASH_CYCLES = `ETX_FLASH_MS * (`ETX_CLK_HZ / 1000),
  parameter ERR_DIV_MIN  = 1000
) (
  input  wire               ref_clk,
  input  wire               rst_n,
  input  wire [7:0]         addr,
  input  wire [31:0]        wdata,
  input  wire               wr,
  input  wire               rd,
  output reg  [31:0]        rdata,
  input  wire [ALARM_W-1:0] alarm_in,
  input  wire               rx_err,
  input  wire               rx_fail,
  input  wire               bit_stb,
  input  wire [4:0]         slot_idx,
  input  wire [2:0]         bit_idx,
  input  wire               frm_bit,
  input  wire               frm_val,
  input  wire               dl_bit,
  input  wire               nfas_frame,
  input  wire               mf_frame0,
  input  wire               live_in,
  output reg                tx_data,
  output reg                tx_en,
  output reg  [ALARM_W-1:0] led_status,
  output reg                led_history,
  output reg                led_freeze,
  output reg                framing_resync,
  output wire               cmp_en,
  output wire               test_running
);
  function [16:0] dur_secs;
    input [2:0] c;
    begin
      case (c)
        3'h1: dur_secs = 17'd1 * `ETX_MIN_S;
        3'h2: dur_secs = 17'd15 * `ETX_MIN_S;
        3'h3: dur_secs = 17'd30 * `ETX_MIN_S;
        3'h4: dur_secs = 17'd60 * `ETX_MIN_S;
        3'h5: dur_secs = 17'd1440 * `ETX_MIN_S;
        default: dur_secs = 17'd0;
      endcase
    end
  endfunction
  function [10:0] sto_secs;
    input [1:0] c;
    begin
      case (c)
        2'h1: sto_secs = 11'd1 * `ETX_MIN_S;
        2'h2: sto_secs = 11'd2 * `ETX_MIN_S;
        2'h3: sto_secs = 11'd30 * `ETX_MIN_S;
        default: sto_secs = 11'd0;
      endcase
    end
  endfunction
  // {length, tap} of each prbs polynomial
  function [9:0] prbs_lt;
    input [4:0] p;
    begin
      case (p)
        5'h00: prbs_lt = {5'd6, 5'd5};
        5'h01: prbs_lt = {5'd7, 5'd6};
        5'h02: prbs_lt = {5'd9, 5'd5};
        5'h03: prbs_lt = {5'd11, 5'd9};
        5'h04, 5'h05: prbs_lt = {5'd15, 5'd14};
        5'h06, 5'h07: prbs_lt = {5'd20, 5'd3};
        5'h08: prbs_lt = {5'd20, 5'd17};
        default: prbs_lt = {5'd23, 5'd18};
      endcase
    end
  endfunction
  function [5:0] fix_len;
    input [4:0] p;
    begin
      case (p)
        5'h0D: fix_len = 6'd2;
        5'h0E: fix_len = 6'd24;
        5'h0F: fix_len = 6'd16;
        5'h10: fix_len = 6'd8;
        5'h11: fix_len = 6'd4;
        default: fix_len = 6'd32;
      endcase
    end
  endfunction
  function [23:0] rate_div;
    input [2:0] r;
    integer i;
    reg [23:0] v;
    begin
      v = ERR_DIV_MIN[23:0];
      for (i = 1; i < 5; i = i + 1)
        if (r > i[2:0])
          v = v * 24'd10;
      rate_div = v;
    end
  endfunction

  reg  [4:0]         pat_q;
  reg  [2:0]         dur_q;
  reg  [1:0]         sto_q;
  reg  [1:0]         res_q;
  reg  [2:0]         rate_q;
  reg                e1_q;
  reg  [2:0]         frm_q;
  reg  [1:0]         asel_q;
  reg  [1:0]         amode_q;
  reg  [31:0]        user_q [0:2];
  reg                run_q;
  reg                done_q;
  reg  [23:0]        sec_cnt_q;
  reg  [16:0]        elap_q;
  reg  [31:0]        errs_q;
  reg  [10:0]        rec_sec_q;
  reg  [ALARM_W-1:0] rec_acc_q;
  reg  [ALARM_W-1:0] hmem [0:(1<<HIST_AW)-1];
  reg  [HIST_AW-1:0] wptr_q;
  reg  [HIST_AW-1:0] cur_q;
  reg  [ALARM_W-1:0] hist_q;
  reg  [ALARM_W-1:0] snap_q;
  reg                frz_q;
  reg                show_q;
  reg  [23:0]        fl_cnt_q;
  reg                fl_q;
  reg  [22:0]        lfsr_q;
  reg  [5:0]         pos_q;
  reg                pend_q;
  reg  [23:0]        rcnt_q;
  wire               wr_test = wr && (addr == `ETX_A_TEST);
  wire               wr_line = wr && (addr == `ETX_A_LINE);
  wire [7:0]         cmd = (wr && addr == `ETX_A_CMD) ?
                           wdata[7:0] : 8'h00;
  wire               restart = cmd[`ETX_C_RESTART] | wr_test;
  wire               sec_tick = (sec_cnt_q == SEC_CYCLES[23:0] - 24'd1);
  wire [10:0]        per = sto_secs(sto_q);
  wire [9:0]         lt = prbs_lt(pat_q);
  wire [4:0]         pl = lt[9:5];
  wire [4:0]         pt = lt[4:0];
  wire               fb = lfsr_q[pl - 5'd1] ^ lfsr_q[pt - 5'd1];
  wire [5:0]         flen = fix_len(pat_q);
  wire               nw_e1 = wdata[`ETX_F_E1];
  wire [1:0]         nw_mode = wdata[`ETX_F_AMODE];
  wire [1:0]         nw_sel = wdata[`ETX_F_ASEL];
  wire [23:0]        p3_w = `ETX_P_3IN24;

  assign test_running = run_q;
  assign cmp_en = run_q && (pat_q != `ETX_P_LIVE);

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pat_q   <= 5'h02;
      dur_q   <= 3'h0;
      sto_q   <= 2'h0;
      res_q   <= 2'h0;
      rate_q  <= 3'h0;
      e1_q    <= 1'b1;
      frm_q   <= 3'h1;
      asel_q  <= `ETX_AS_AIS;
      amode_q <= `ETX_AM_OFF;
      user_q[0] <= 32'h0000_0000;
      user_q[1] <= 32'h0000_0000;
      user_q[2] <= 32'h0000_0000;
    end
    else
    begin
      if (wr_test)
      begin
        pat_q  <= wdata[`ETX_F_PAT];
        dur_q  <= wdata[`ETX_F_DUR];
        sto_q  <= wdata[`ETX_F_STO];
        res_q  <= wdata[`ETX_F_RES];
        rate_q <= wdata[`ETX_F_RATE];
      end
      if (wr_line)
      begin
        e1_q  <= nw_e1;
        frm_q <= wdata[`ETX_F_FRM];
        if (nw_e1 || nw_sel <= `ETX_AS_YEL)
          asel_q <= nw_sel;
        if (nw_mode != `ETX_AM_AUTO || nw_e1)
          amode_q <= nw_mode;
        else
          amode_q <= `ETX_AM_OFF;
      end
      if (wr && addr == `ETX_A_USER0)
        user_q[0] <= wdata;
      if (wr && addr == `ETX_A_USER1)
        user_q[1] <= wdata;
      if (wr && addr == `ETX_A_USER2)
        user_q[2] <= wdata;
    end
  end

  // test timing; results freeze once a fixed run elapses
  always @(posedge ref_clk)
  begin
    if (!rst_n || restart)
    begin
      run_q     <= 1'b1;
      done_q    <= 1'b0;
      sec_cnt_q <= 24'd0;
      elap_q    <= 17'd0;
      errs_q    <= 32'h0000_0000;
    end
    else if (run_q)
    begin
      sec_cnt_q <= sec_tick ? 24'd0 : sec_cnt_q + 24'd1;
      if (rx_err)
        errs_q <= errs_q + 32'h0000_0001;
      if (sec_tick)
      begin
        elap_q <= elap_q + 17'd1;
        if (dur_q != 3'h0 && elap_q + 17'd1 >= dur_secs(dur_q))
        begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // histogram records: or of alarms seen over each period
  always @(posedge ref_clk)
  begin
    if (!rst_n || restart || per == 11'd0)
    begin
      rec_sec_q <= 11'd0;
      rec_acc_q <= {ALARM_W{1'b0}};
      wptr_q    <= {HIST_AW{1'b0}};
    end
    else if (run_q)
    begin
      rec_acc_q <= rec_acc_q | alarm_in;
      if (sec_tick)
      begin
        if (rec_sec_q + 11'd1 == per)
        begin
          hmem[wptr_q] <= rec_acc_q | alarm_in;
          wptr_q       <= wptr_q + 1'b1;
          rec_acc_q    <= {ALARM_W{1'b0}};
          rec_sec_q    <= 11'd0;
        end
        else
          rec_sec_q <= rec_sec_q + 11'd1;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      cur_q <= {HIST_AW{1'b0}};
    else if (cmd[`ETX_C_LEFT] && cur_q != {HIST_AW{1'b0}})
      cur_q <= cur_q - 1'b1;
    else if (cmd[`ETX_C_RIGHT] && cur_q != {HIST_AW{1'b1}})
      cur_q <= cur_q + 1'b1;
  end

  // led history; a new alarm beats a clear in the same cycle
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hist_q   <= {ALARM_W{1'b0}};
      snap_q   <= {ALARM_W{1'b0}};
      frz_q    <= 1'b0;
      show_q   <= 1'b0;
      fl_cnt_q <= 24'd0;
      fl_q     <= 1'b0;
    end
    else
    begin
      hist_q <= (cmd[`ETX_C_CLEAR] ? {ALARM_W{1'b0}} : hist_q)
                | alarm_in;
      if (cmd[`ETX_C_FREEZE])
      begin
        frz_q  <= ~frz_q;
        snap_q <= led_status;
      end
      if (cmd[`ETX_C_CLEAR])
      begin
        show_q <= 1'b0;
        frz_q  <= 1'b0;
      end
      else if (cmd[`ETX_C_SHOW])
        show_q <= ~show_q;
      if (fl_cnt_q == FLASH_CYCLES[23:0] - 24'd1)
      begin
        fl_cnt_q <= 24'd0;
        fl_q     <= ~fl_q;
      end
      else
        fl_cnt_q <= fl_cnt_q + 24'd1;
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      led_status     <= {ALARM_W{1'b0}};
      led_history    <= 1'b0;
      led_freeze     <= 1'b0;
      framing_resync <= 1'b0;
    end
    else
    begin
      if (show_q)
        led_status <= hist_q;
      else if (!frz_q)
        led_status <= alarm_in;
      else
        led_status <= snap_q;
      led_freeze     <= frz_q;
      led_history    <= show_q | (fl_q & (|hist_q));
      framing_resync <= cmd[`ETX_C_RESYNC];
    end
  end

  // pattern source and error insertion, one step per line bit
  reg  pbit;
  reg  err;
  reg  act;
  reg  txd;
  always @*
  begin
    pbit = 1'b0;
    case (pat_q)
      5'h05, 5'h07, 5'h0A: pbit = ~lfsr_q[pl - 5'd1];
      5'h0B: pbit = 1'b1;
      5'h0C: pbit = 1'b0;
      5'h0D: pbit = pos_q[0];
      5'h0E: pbit = p3_w[pos_q[4:0]];
      5'h0F, 5'h10, 5'h11: pbit = (pos_q == 6'd0);
      5'h12: pbit = user_q[0][pos_q[4:0]];
      5'h13: pbit = user_q[1][pos_q[4:0]];
      5'h14: pbit = user_q[2][pos_q[4:0]];
      `ETX_P_LIVE: pbit = live_in;
      default: pbit = lfsr_q[pl - 5'd1];
    endcase
    err = run_q && !frm_bit && (pend_q ||
          (rate_q != 3'h0 && rcnt_q == rate_div(rate_q) - 24'd1));
    act = (amode_q == `ETX_AM_ON) ||
          (amode_q == `ETX_AM_AUTO && e1_q && rx_fail);
    txd = frm_bit ? frm_val : (pbit ^ err);
    if (act)
    begin
      if (asel_q == `ETX_AS_AIS)
        txd = 1'b1;
      else if (!e1_q)
      begin
        if ((frm_q == `ETX_FR_SF || frm_q == `ETX_FR_SLC) &&
            !frm_bit && bit_idx == `ETX_T1_B2)
          txd = 1'b0;
        if (frm_q == `ETX_FR_ESF && dl_bit)
          txd = 1'b0;
        if (frm_q == `ETX_FR_T1DM && !frm_bit &&
            slot_idx == `ETX_T1DM_SLOT && bit_idx == `ETX_T1DM_YBIT)
          txd = 1'b0;
      end
      else if (asel_q == `ETX_AS_RAI && slot_idx == 5'h00 &&
               nfas_frame && bit_idx == `ETX_E1_ABIT)
        txd = 1'b1;
      else if (asel_q == `ETX_AS_MRAI && slot_idx == `ETX_E1_TS16 &&
               mf_frame0 && bit_idx == `ETX_E1_YBIT)
        txd = 1'b1;
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lfsr_q  <= 23'h00_0001;
      pos_q   <= 6'd0;
      pend_q  <= 1'b0;
      rcnt_q  <= 24'd0;
      tx_data <= 1'b0;
      tx_en   <= 1'b0;
    end
    else
    begin
      // one pending error per command, even if it lands on insertion
      pend_q <= (pend_q & ~(bit_stb & err)) |
                (cmd[`ETX_C_SINGLE] & run_q);
      // on an E1 line the signal loss alarm turns the transmitter off
      tx_en <= !(act && e1_q && asel_q == `ETX_AS_LOS);
      if (bit_stb)
      begin
        tx_data <= txd;
        if (lfsr_q == 23'h00_0000)
          lfsr_q <= 23'h00_0001; // escape the locked state
        else
          lfsr_q <= {lfsr_q[21:0], fb};
        pos_q <= (pos_q + 6'd1 >= flen) ? 6'd0 : pos_q + 6'd1;
        if (!frm_bit)
          rcnt_q <= (err || rate_q == 3'h0) ? 24'd0 : rcnt_q + 24'd1;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n || !rd)
      rdata <= 32'h0000_0000;
    else
      case (addr)
        `ETX_A_TEST: rdata <= {17'd0, rate_q, res_q, sto_q, dur_q, pat_q};
        `ETX_A_LINE: rdata <= {24'd0, amode_q, asel_q, frm_q, e1_q};
        `ETX_A_STAT: rdata <= {27'd0, show_q, |hist_q, frz_q,
                               done_q, run_q};
        `ETX_A_HIST: rdata <= {{(32-ALARM_W){1'b0}}, hist_q};
        `ETX_A_ELAP: rdata <= {15'd0, elap_q};
        `ETX_A_ERRS: rdata <= errs_q;
        `ETX_A_HPTR: rdata <= {{(32-2*HIST_AW){1'b0}}, wptr_q, cur_q};
        `ETX_A_HREC: rdata <= {{(32-ALARM_W){1'b0}}, hmem[cur_q]};
        `ETX_A_USER0: rdata <= user_q[0];
        `ETX_A_USER1: rdata <= user_q[1];
        `ETX_A_USER2: rdata <= user_q[2];
        default: rdata <= 32'h0000_0000;
      endcase
  end
endmodule // etx_ctrl

// File: verification/etx_chk.sv
`timescale 1ns/1ps
`include "etx_defs.vh"
module etx_chk #(
  parameter ALARM_W = 12
) (
  input wire               ref_clk,
  input wire               rst_n,
  input wire [7:0]         addr,
  input wire [31:0]        wdata,
  input wire               wr,
  input wire               bit_stb,
  input wire [4:0]         slot_idx,
  input wire [2:0]         bit_idx,
  input wire               frm_bit,
  input wire               dl_bit,
  input wire               nfas_frame,
  input wire               mf_frame0,
  input wire               tx_data,
  input wire               tx_en,
  input wire [ALARM_W-1:0] led_status,
  input wire               led_freeze
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  wire        on_w = cfg_q[7:6] == `ETX_AM_ON;
  wire        e1_w = on_w && cfg_q[0];
  wire        t1y_w = on_w && !cfg_q[0] && cfg_q[5:4] == `ETX_AS_YEL;
  wire [2:0]  fr_w = cfg_q[3:1];
  // refused alarm selections keep the old value and a refused auto mode loads off, so the mirror must too
  always @*
  begin
    cfg_d = wdata[7:0];
    if (!wdata[0] && wdata[5])
      cfg_d[5:4] = cfg_q[5:4];
    if (!wdata[0] && wdata[7:6] == `ETX_AM_AUTO)
      cfg_d[7:6] = `ETX_AM_OFF;
  end
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      cfg_q <= 8'h03;
    else if (wr && addr == `ETX_A_LINE)
      cfg_q <= cfg_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_frozen;
    led_freeze [*3];
  endsequence
  property p_ais;
    on_w && cfg_q[5:4] == `ETX_AS_AIS && bit_stb |=> tx_data;
  endproperty
  a_ais: assert property (p_ais) else $error("ais bit low");
  property p_los;
    e1_w && cfg_q[5:4] == `ETX_AS_LOS |=> !tx_en;
  endproperty
  a_los: assert property (p_los) else $error("tx on in loss");
  property p_sf;
    t1y_w && (fr_w == `ETX_FR_SF || fr_w == `ETX_FR_SLC) && bit_stb
      && !frm_bit && bit_idx == `ETX_T1_B2 |=> !tx_data;
  endproperty
  a_sf: assert property (p_sf) else $error("bit 2 not low");
  property p_esf;
    t1y_w && fr_w == `ETX_FR_ESF && bit_stb && dl_bit |=> !tx_data;
  endproperty
  a_esf: assert property (p_esf) else $error("link bit high");
  property p_t1dm;
    t1y_w && fr_w == `ETX_FR_T1DM && bit_stb && slot_idx == `ETX_T1DM_SLOT
      && bit_idx == `ETX_T1DM_YBIT |=> !tx_data;
  endproperty
  a_t1dm: assert property (p_t1dm) else $error("sync y bit high");
  property p_rai;
    e1_w && cfg_q[5:4] == `ETX_AS_RAI && bit_stb && nfas_frame
      && slot_idx == 5'h00 && bit_idx == `ETX_E1_ABIT |=> tx_data;
  endproperty
  a_rai: assert property (p_rai) else $error("a bit low");
  property p_mrai;
    e1_w && cfg_q[5:4] == `ETX_AS_MRAI && bit_stb && mf_frame0
      && slot_idx == `ETX_E1_TS16 && bit_idx == `ETX_E1_YBIT |=> tx_data;
  endproperty
  a_mrai: assert property (p_mrai) else $error("ts16 y low");
  property p_frz;
    s_frozen |-> $stable(led_status);
  endproperty
  a_frz: assert property (p_frz) else $error("frozen leds moved");
endmodule // etx_chk

bind etx_ctrl etx_chk #(.ALARM_W(ALARM_W)) etx_chk_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .bit_stb(bit_stb), .slot_idx(slot_idx), .bit_idx(bit_idx),
  .frm_bit(frm_bit), .dl_bit(dl_bit), .nfas_frame(nfas_frame),
  .mf_frame0(mf_frame0), .tx_data(tx_data), .tx_en(tx_en),
  .led_status(led_status), .led_freeze(led_freeze)
);

// File: verification/etx_line_model.sv
`timescale 1ns/1ps
module etx_line_model (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        slow,
  output logic       bit_stb,
  output logic [4:0] slot_idx,
  output logic [2:0] bit_idx,
  output logic       frm_bit,
  output logic       frm_val,
  output logic       dl_bit,
  output logic       nfas_frame,
  output logic       mf_frame0,
  output logic       live_in
);
  logic [7:0] pos_q;
  logic [3:0] frame_q;
  logic [1:0] gap_q;
  // position only moves on a strobe, as behind a real line interface
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pos_q <= 8'h00;
      frame_q <= 4'h0;
      gap_q <= 2'h0;
    end
    else
    begin
      gap_q <= bit_stb ? 2'h0 : gap_q + 2'h1;
      if (bit_stb)
        {frame_q, pos_q} <= {frame_q, pos_q} + 12'h001;
    end
  end
  // slow line leaves two idle cycles between bits
  assign bit_stb = rst_n && (!slow || gap_q == 2'h2);
  assign {slot_idx, bit_idx} = pos_q;
  assign frm_bit = pos_q == 8'h00;
  assign frm_val = frame_q[1];
  assign dl_bit = frm_bit && frame_q[0];
  assign nfas_frame = frame_q[0];
  assign mf_frame0 = frame_q == 4'h0;
  assign live_in = pos_q[0] ^ pos_q[3];
endmodule // etx_line_model

// File: verification/tb_etx_ctrl.sv
`timescale 1ns/1ps
`include "etx_defs.vh"
module tb_etx_ctrl;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic [11:0] alarm_in = 12'h000;
  logic        rx_err = 1'b0;
  logic        rx_fail = 1'b0;
  logic        slow = 1'b0;
  logic [11:0] a_pat;
  logic [11:0] b_pat;
  logic [31:0] r;
  logic [31:0] exp_q [$];
  logic [4:0]  pats [3] = '{5'h0B, 5'h12, 5'h0C};
  logic [2:0]  t1_fr [5] = '{3'h4, 3'h3, 3'h5, 3'h6, 3'h4};
  wire  [31:0] rdata;
  wire  [11:0] led_status;
  wire  [4:0]  slot_idx;
  wire  [2:0]  bit_idx;
  wire         bit_stb, frm_bit, frm_val, dl_bit, nfas_frame, mf_frame0;
  wire         live_in, tx_data, tx_en, led_history, led_freeze;
  wire         framing_resync, cmp_en, test_running;
  int          mismatches = 0;
  int          comparisons = 0;
  int          seed = 32'h02f3;
  int          ones;
  int          bits;
  int          errs;
  always #50 ref_clk = ~ref_clk;
  etx_ctrl #(
    .SEC_CYCLES(10),
    .FLASH_CYCLES(4),
    .ERR_DIV_MIN(4)
  ) etx_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .alarm_in(alarm_in),
    .rx_err(rx_err), .rx_fail(rx_fail), .bit_stb(bit_stb),
    .slot_idx(slot_idx), .bit_idx(bit_idx), .frm_bit(frm_bit),
    .frm_val(frm_val), .dl_bit(dl_bit), .nfas_frame(nfas_frame),
    .mf_frame0(mf_frame0), .live_in(live_in), .tx_data(tx_data),
    .tx_en(tx_en), .led_status(led_status), .led_history(led_history),
    .led_freeze(led_freeze), .framing_resync(framing_resync),
    .cmp_en(cmp_en), .test_running(test_running)
  );
  etx_line_model etx_line_model_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .bit_stb(bit_stb),
    .slot_idx(slot_idx), .bit_idx(bit_idx), .frm_bit(frm_bit),
    .frm_val(frm_val), .dl_bit(dl_bit), .nfas_frame(nfas_frame),
    .mf_frame0(mf_frame0), .live_in(live_in)
  );
  task automatic check(input [31:0] seen, input [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_reg(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask
  task automatic cmd(input int b);
    wr_reg(`ETX_A_CMD, 32'h0000_0001 << b);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // counts payload ones only; overhead bits follow the framer
  task automatic count_ones(input int n);
    ones = 0;
    bits = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      if (bit_stb && !frm_bit)
      begin
        #1;
        bits++;
        ones += (tx_data === 1'b1);
      end
    end
  endtask
  // read data stand one cycle only, so compare in that cycle
  always @(posedge ref_clk)
  begin
    rd_seen <= rd;
    if (rd_seen)
      check(rdata, exp_q.pop_front());
  end
  initial
  begin
    idle(60000);
    mismatches++;
    close_out;
  end
  initial
  begin
    idle(6);
    rst_n <= 1'b1;
    rd_reg(`ETX_A_LINE, 32'h0000_0003);
    rd_reg(`ETX_A_TEST, 32'h0000_0002);
    rd_reg(8'h30, 32'h0000_0000);
    wr_reg(`ETX_A_TEST, 32'h0000_0C0C);
    rd_reg(`ETX_A_TEST, 32'h0000_0C0C);
    check(cmp_en, 1'b1);
    cmd(`ETX_C_LEFT);
    rd_reg(`ETX_A_HPTR, 32'h0000_0000);
    cmd(`ETX_C_RIGHT);
    cmd(`ETX_C_RIGHT);
    cmd(`ETX_C_LEFT);
    rd_reg(`ETX_A_HPTR, 32'h0000_0001);
    wr_reg(`ETX_A_TEST, 32'h0000_0015);
    idle(2);
    check(cmp_en, 1'b0);
    $display("test setup done");
    wr_reg(`ETX_A_USER0, 32'hFFFF_FFFF);
    wr_reg(`ETX_A_LINE, 32'h0000_0001);
    foreach (pats[i])
    begin
      wr_reg(`ETX_A_TEST, {27'h0, pats[i]});
      count_ones(300);
      check(ones, pats[i] == 5'h0C ? 0 : bits);
    end
    cmd(`ETX_C_SINGLE);
    count_ones(300);
    check(ones, 1);
    wr_reg(`ETX_A_TEST, 32'h0000_200C);
    count_ones(800);
    check(ones >= bits / 40 && ones <= bits / 40 + 1, 1'b1);
    $display("test pattern done");
    a_pat = 12'($random(seed)) | 12'h001;
    b_pat = 12'($random(seed)) | 12'h002;
    alarm_in <= a_pat;
    idle(3);
    alarm_in <= 12'h000;
    idle(3);
    rd_reg(`ETX_A_HIST, {20'h0, a_pat});
    check(led_status, 12'h000);
    ones = 0;
    repeat (20) @(posedge ref_clk) ones += (led_history === 1'b1);
    check(ones > 0 && ones < 20, 1'b1);
    cmd(`ETX_C_SHOW);
    idle(3);
    check(led_status, a_pat);
    check(led_history, 1'b1);
    cmd(`ETX_C_SHOW);
    alarm_in <= b_pat;
    idle(3);
    cmd(`ETX_C_FREEZE);
    alarm_in <= 12'h000;
    idle(5);
    check(led_status, b_pat);
    check(led_freeze, 1'b1);
    cmd(`ETX_C_FREEZE);
    idle(3);
    check(led_status, 12'h000);
    check(led_freeze, 1'b0);
    rd_reg(`ETX_A_HIST, {20'h0, a_pat | b_pat});
    cmd(`ETX_C_CLEAR);
    rd_reg(`ETX_A_HIST, 32'h0000_0000);
    $display("test leds done");
    wr_reg(`ETX_A_TEST, 32'h0000_012C);
    errs = 0;
    repeat (50)
    begin
      @(posedge ref_clk);
      r = $random(seed);
      rx_err <= r[0];
      errs += r[0];
    end
    @(posedge ref_clk);
    rx_err <= 1'b0;
    idle(700);
    repeat (30) @(posedge ref_clk) rx_err <= ~rx_err;
    rx_err <= 1'b0;
    rd_reg(`ETX_A_ERRS, errs);
    rd_reg(`ETX_A_STAT, 32'h0000_0002);
    rd_reg(`ETX_A_ELAP, 32'h0000_003C);
    rd_reg(`ETX_A_HPTR, 32'h0000_0041);
    check(test_running, 1'b0);
    wr_reg(`ETX_A_TEST, 32'h0000_000C);
    cmd(`ETX_C_RESYNC);
    #1;
    check(framing_resync, 1'b1);
    $display("test duration done");
    slow <= 1'b1;
    foreach (t1_fr[i])
    begin
      wr_reg(`ETX_A_LINE, {24'h0, 2'b01,
        i == 4 ? `ETX_AS_AIS : `ETX_AS_YEL, t1_fr[i], 1'b0});
      count_ones(800);
      if (i == 4)
        check(ones, bits);
    end
    wr_reg(`ETX_A_LINE, 32'h0000_00B8);
    rd_reg(`ETX_A_LINE, 32'h0000_0008);
    slow <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(`ETX_A_LINE, {24'h0, 2'b01, s[1:0], 3'h2, 1'b1});
      count_ones(5000);
      if (s == 0)
        check(ones, bits);
    end
    check(tx_en, 1'b0);
    wr_reg(`ETX_A_LINE, 32'h0000_0085);
    rd_reg(`ETX_A_LINE, 32'h0000_0085);
    rx_fail <= 1'b1;
    idle(5);
    count_ones(100);
    check(ones, bits);
    rx_fail <= 1'b0;
    wr_reg(`ETX_A_LINE, 32'h0000_0005);
    count_ones(600);
    check(ones, 0);
    check(tx_en, 1'b1);
    $display("test alarms done");
    close_out;
  end
endmodule // tb_etx_ctrl
